/* File: core/decim_top.sv */
// decimation chain, restart timing, frame output
`timescale 1ns/1ps
`include "decim_cfg.svh"
module decim_top import decim_pkg::*; #(
  parameter logic [15:0] SETTLE_N128 = `SETL_N128,
  parameter logic [15:0] SETTLE_N256 = `SETL_N256,
  parameter logic [15:0] SETTLE_L128 = `SETL_L128,
  parameter logic [15:0] SETTLE_L256 = `SETL_L256
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        restart_pin,
  input  wire logic        decimation_select,
  input  wire logic        low_power,
  input  wire logic [15:0] mod_word,
  output logic             modulator_sample_clock,
  output logic             serial_clock_out,
  output logic             frame_strobe_out,
  output logic             serial_data_out,
  output logic             settled_flag,
  output logic [15:0]      fine_group_delay
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] mode_pick(
    input logic        lp,
    input logic        d128,
    input logic [15:0] n128,
    input logic [15:0] n256,
    input logic [15:0] l128,
    input logic [15:0] l256
  );
    mode_pick = lp ? (d128 ? l128 : l256) : (d128 ? n128 : n256);
  endfunction : mode_pick

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] rst_pin_ff;
  logic [1:0] dec_pin_ff;
  logic [1:0] lp_pin_ff;
  logic       restart_d_ff;

  // (RULE_09) sampled every rising edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rst_pin_ff   <= 2'h0;
      dec_pin_ff   <= 2'h0;
      lp_pin_ff    <= 2'h0;
      restart_d_ff <= 1'b0;
    end else begin
      rst_pin_ff   <= {rst_pin_ff[0], restart_pin};
      dec_pin_ff   <= {dec_pin_ff[0], decimation_select};
      lp_pin_ff    <= {lp_pin_ff[0], low_power};
      restart_d_ff <= rst_pin_ff[1];
    end
  end

  wire rise_ev = rst_pin_ff[1] & ~restart_d_ff;
  wire fall_ev = ~rst_pin_ff[1] & restart_d_ff;

  // ****************************************
  // mode latch
  // ****************************************
  logic low_ff;
  logic dec128_ff;
  logic [15:0] fine_gd_ff;

  // mode is frozen at restart so a pin change mid-run cannot tear frames
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      low_ff    <= 1'b0;
      dec128_ff <= 1'b0;
    end else if (rise_ev) begin
      low_ff    <= lp_pin_ff[1];
      dec128_ff <= dec_pin_ff[1];
    end
  end

  wire [15:0] offset_sel = mode_pick(low_ff, dec128_ff,
    `OFFS_N128, `OFFS_N256, `OFFS_L128, `OFFS_L256);
  wire [15:0] settle_sel = mode_pick(low_ff, dec128_ff,
    SETTLE_N128, SETTLE_N256, SETTLE_L128, SETTLE_L256);
  wire [15:0] comp_sel = mode_pick(low_ff, dec128_ff,
    `COMP_N128, `COMP_N256, `COMP_L128, `COMP_L256);
  wire [15:0] filt_sel = mode_pick(low_ff, dec128_ff,
    `FILT_N128, `FILT_N256, `FILT_L128, `FILT_L256);
  // (RULE_03) frame rate select
  // (RULE_07) overall ratio select
  wire [15:0] odr_sel = dec128_ff ? `ODR_128 : `ODR_256;
  // (RULE_05) second stage factor
  wire [15:0] s2_pick = mode_pick(low_ff, dec128_ff,
    {10'h000, `S2_N128}, {10'h000, `S2_N256},
    {10'h000, `S2_L128}, {10'h000, `S2_L256});
  wire [5:0]  s2_factor = s2_pick[5:0];
  // (RULE_01) sample clock divide
  wire [2:0] div_sel = low_ff ? `DIV_LOW : `DIV_NORMAL;

  // (RULE_14) delay in master clocks
  // (RULE_15) sum of two delays
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fine_gd_ff <= 16'h0000;
    end else begin
      fine_gd_ff <= comp_sel + filt_sel;
    end
  end

  // ****************************************
  // restart sequencing
  // ****************************************
  sync_state_type state_ff;
  sync_state_type nxt_state;
  mclk_count_type cnt_ff;
  mclk_count_type settle_cnt_ff;
  logic           settled_ff;

  wire run = (state_ff != ST_IDLE);
  wire offset_done = (state_ff == ST_OFFSET) && (cnt_ff == offset_sel - 16'h0002);
  wire odr_done = (state_ff == ST_RUN) && (cnt_ff == odr_sel - 16'h0001);
  // (RULE_13) one tick per conversion period
  wire frame_tick = offset_done | odr_done;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:   nxt_state = ST_IDLE;
      ST_OFFSET: nxt_state = offset_done ? ST_RUN : ST_OFFSET;
      ST_RUN:    nxt_state = ST_RUN;
      default:   nxt_state = ST_IDLE;
    endcase
    // (RULE_11) rise starts processing
    if (rise_ev) begin
      nxt_state = ST_OFFSET;
    end
    // (RULE_17) fall stops and clears
    if (fall_ev) begin
      nxt_state = ST_IDLE;
    end
  end

  // (RULE_12) offset then period counting
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (rise_ev | frame_tick | ~run) ? 16'h0000 : cnt_ff + 16'h0001;
    end
  end

  // (RULE_08) settle count from rise
  // (RULE_18) cleared on either edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      settle_cnt_ff <= 16'h0000;
      settled_ff    <= 1'b0;
    end else if (rise_ev | fall_ev) begin
      settle_cnt_ff <= 16'h0000;
      settled_ff    <= 1'b0;
    end else if (run && !settled_ff) begin
      settle_cnt_ff <= settle_cnt_ff + 16'h0001;
      settled_ff    <= (settle_cnt_ff == settle_sel - 16'h0002);
    end
  end

  // ****************************************
  // sample clock divider
  // ****************************************
  logic [2:0] div_ff;
  logic       sco_ff;

  wire modulator_sample_clock_en = run && (div_ff == div_sel - 3'h1);

  // (RULE_01) divider restarts with the chain
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= 3'h0;
      sco_ff <= 1'b0;
    end else if (rise_ev | ~run) begin
      div_ff <= 3'h0;
      sco_ff <= 1'b0;
    end else begin
      div_ff <= modulator_sample_clock_en ? 3'h0 : div_ff + 3'h1;
      if (modulator_sample_clock_en) begin
        sco_ff <= 1'b1;
      end else if (div_ff == (div_sel >> 1) - 3'h1) begin
        sco_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // filter chain
  // ****************************************
  logic        fifo_in_ready;
  logic        s1_valid;
  logic        s2_valid;
  logic        s3_valid;
  logic [17:0] s1_data;
  logic [22:0] s2_data;
  logic [23:0] s3_data;

  // (RULE_02) one word per sample clock
  // the chain stalls only when the fifo is full, which the frame drain outpaces
  wire chain_ce = modulator_sample_clock_en & fifo_in_ready;
  wire chain_clr = rise_ev | fall_ev;

  // (RULE_04) first stage by four
  fir_stage #(.IN_W(16), .OUT_W(18)) u_stage1 (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clr       (chain_clr),
    .factor    (`S1_FACTOR),
    .in_valid  (chain_ce),
    .in_data   (mod_word),
    .out_valid (s1_valid),
    .out_data  (s1_data)
  );

  fir_stage #(.IN_W(18), .OUT_W(23)) u_stage2 (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clr       (chain_clr),
    .factor    (s2_factor),
    .in_valid  (s1_valid),
    .in_data   (s1_data),
    .out_valid (s2_valid),
    .out_data  (s2_data)
  );

  // (RULE_06) fixed final halving
  fir_stage #(.IN_W(23), .OUT_W(24)) u_stage3 (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clr       (chain_clr),
    .factor    (`S3_FACTOR),
    .in_valid  (s2_valid),
    .in_data   (s2_data),
    .out_valid (s3_valid),
    .out_data  (s3_data)
  );

  // ****************************************
  // result fifo and frame serialiser
  // ****************************************
  logic        fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic [31:0] shift_ff;
  logic [31:0] held_ff;
  logic [5:0]  bit_ff;
  logic        fso_ff;

  wire [31:0] status_word = {s3_data, settled_ff, low_ff, dec128_ff, 5'h00};

  sample_fifo #(.WIDTH(32), .DEPTH(16)) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .flush     (chain_clr),
    .in_valid  (s3_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (status_word),
    .out_valid (fifo_out_valid),
    .out_ready (frame_tick),
    .out_data  (fifo_out_data)
  );

  // (RULE_16) frame held low for 32 sample clocks
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shift_ff <= 32'h0000_0000;
      held_ff  <= 32'h0000_0000;
      bit_ff   <= 6'h00;
      fso_ff   <= 1'b1;
    end else if (chain_clr) begin
      bit_ff <= 6'h00;
      fso_ff <= 1'b1;
    end else if (frame_tick) begin
      // an empty fifo repeats the previous word rather than skip a frame
      shift_ff <= fifo_out_valid ? fifo_out_data : held_ff;
      held_ff  <= fifo_out_valid ? fifo_out_data : held_ff;
      bit_ff   <= 6'h00;
      fso_ff   <= 1'b0;
    end else if (!fso_ff && modulator_sample_clock_en) begin
      shift_ff <= {shift_ff[30:0], 1'b0};
      bit_ff   <= bit_ff + 6'h01;
      fso_ff   <= (bit_ff == `FRAME_BITS - 6'h01);
    end
  end

  assign modulator_sample_clock = modulator_sample_clock_en;
  assign serial_clock_out       = sco_ff;
  assign frame_strobe_out       = fso_ff;
  assign serial_data_out        = shift_ff[31];
  assign settled_flag           = settled_ff;
  assign fine_group_delay       = fine_gd_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic [15:0] since_rise_ff;
  logic [15:0] since_fall_ff;
  logic        first_ff;
  logic [5:0]  h1_ff;
  logic [5:0]  h2_ff;
  logic [5:0]  h3_ff;
  logic [5:0]  hf_ff;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      since_rise_ff <= 16'h0000;
      since_fall_ff <= 16'h0000;
      first_ff      <= 1'b0;
      h1_ff         <= 6'h00;
      h2_ff         <= 6'h00;
      h3_ff         <= 6'h00;
      hf_ff         <= 6'h00;
    end else begin
      since_rise_ff <= rise_ev ? 16'h0001 : since_rise_ff + 16'h0001;
      since_fall_ff <= frame_tick ? 16'h0001 : since_fall_ff + 16'h0001;
      first_ff      <= rise_ev ? 1'b1 : (frame_tick ? 1'b0 : first_ff);
      h1_ff <= chain_clr ? 6'h00 : (s1_valid ? {5'h00, chain_ce} : h1_ff + {5'h00, chain_ce});
      h2_ff <= chain_clr ? 6'h00 : (s2_valid ? {5'h00, s1_valid} : h2_ff + {5'h00, s1_valid});
      h3_ff <= chain_clr ? 6'h00 : (s3_valid ? {5'h00, s2_valid} : h3_ff + {5'h00, s2_valid});
      hf_ff <= frame_tick ? 6'h00 : hf_ff + {5'h00, !fso_ff && modulator_sample_clock_en};
    end
  end

  sequence normal_pulse_s;
    modulator_sample_clock_en && !low_ff && !rise_ev && !fall_ev;
  endsequence

  a_modulator_sample_clock_normal_gap: assert property ( // RULE_01
    normal_pulse_s ##1 (!rise_ev && !fall_ev) |-> !modulator_sample_clock_en ##1 modulator_sample_clock_en)
    else $error("normal mode sample clock not every two cycles");
  a_modulator_sample_clock_low_gap: assert property ( // RULE_01
    (modulator_sample_clock_en && low_ff && !rise_ev && !fall_ev) ##1 (!rise_ev && !fall_ev)[*3]
      |=> modulator_sample_clock_en && !$past(modulator_sample_clock_en) && !$past(modulator_sample_clock_en, 2) && !$past(modulator_sample_clock_en, 3))
    else $error("low power sample clock not every four cycles");
  a_stage1_ratio: assert property ( // RULE_04
    s1_valid |-> h1_ff == `S1_FACTOR)
    else $error("first stage did not take four words");
  a_stage2_ratio: assert property ( // RULE_05
    s2_valid |-> h2_ff == s2_factor)
    else $error("second stage ratio wrong");
  a_stage3_ratio: assert property ( // RULE_06
    s3_valid |-> h3_ff == `S3_FACTOR)
    else $error("third stage ratio wrong");
  a_first_frame: assert property ( // RULE_12
    $fell(fso_ff) && $past(first_ff) |-> since_rise_ff == offset_sel)
    else $error("first frame strobe not at restart offset");
  a_frame_period: assert property ( // RULE_13
    $fell(fso_ff) && !$past(first_ff) && !$past(chain_clr) |-> $past(since_fall_ff) == odr_sel)
    else $error("frame period differs from output rate");
  a_frame_width: assert property ( // RULE_16
    $rose(fso_ff) && !$past(chain_clr) |-> hf_ff == `FRAME_BITS)
    else $error("frame strobe not 32 serial clocks");
  a_settle_time: assert property ( // RULE_08
    $rose(settled_ff) |-> since_rise_ff == settle_sel)
    else $error("settled flag at wrong time");
  a_restart_clear: assert property ( // RULE_18
    fall_ev |=> !settled_ff && !run && fso_ff)
    else $error("restart fall did not clear state");
endmodule : decim_top

/* File: core/fir_stage.sv */
// one decimating boxcar stage of the chain
`timescale 1ns/1ps
module fir_stage #(
  parameter int IN_W  = 16,
  parameter int OUT_W = 18
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clr,
  input  wire logic [5:0]       factor,
  input  wire logic             in_valid,
  input  wire logic [IN_W-1:0]  in_data,
  output logic                  out_valid,
  output logic [OUT_W-1:0]      out_data
);
  logic [OUT_W-1:0] acc_ff;
  logic [5:0]       cnt_ff;
  logic             valid_ff;
  logic [OUT_W-1:0] data_ff;
  wire  [OUT_W-1:0] ext_in = {{(OUT_W-IN_W){in_data[IN_W-1]}}, in_data};
  wire  [OUT_W-1:0] nxt_sum = acc_ff + ext_in;
  wire              last = (cnt_ff == factor - 6'h01);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ff   <= '0;
      cnt_ff   <= 6'h00;
      valid_ff <= 1'b0;
      data_ff  <= '0;
    end else if (clr) begin
      acc_ff   <= '0;
      cnt_ff   <= 6'h00;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= in_valid & last;
      if (in_valid) begin
        acc_ff <= last ? '0 : nxt_sum;
        cnt_ff <= last ? 6'h00 : cnt_ff + 6'h01;
        if (last) begin
          data_ff <= nxt_sum;
        end
      end
    end
  end

  assign out_valid = valid_ff;
  assign out_data  = data_ff;
endmodule : fir_stage

/* File: core/sample_fifo.sv */
// result fifo, flip-flop storage
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire              empty = (wr_ff == rd_ff);
  wire              full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire              push = in_valid & ~full;
  wire              pop = out_ready & ~empty;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else if (flush) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= push ? wr_ff + {{AW{1'b0}}, 1'b1} : wr_ff;
      rd_ff <= pop ? rd_ff + {{AW{1'b0}}, 1'b1} : rd_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = empty ? '0 : mem_ff[rd_ff[AW-1:0]];
endmodule : sample_fifo

/* File: include/decim_cfg.svh */
// constants for the decimation chain and restart timing
// What this block does
// (RULE_01) modulator sample clock is master clock over two, or over four in low power
// (RULE_02) one modulator word enters the chain on each modulator sample clock
// (RULE_03) chain output rate is sample rate over 64 or more, by decimation setting
// (RULE_04) first stage takes every modulator word and decimates by four
// (RULE_05) second stage decimation factor is selectable from eight to thirty-two
// (RULE_06) third stage always decimates by two
// (RULE_07) decimation select high gives 128 overall, low gives 256; in low power the chain gives 64 and 128 instead
// (RULE_08) settled flag rises about twice filter delay plus computation delay after restart
// (RULE_09) restart input level is sampled on every rising master clock edge
// (RULE_10) controller should raise restart on a falling master clock edge; the testbench raises it 1 ns after a rising edge
// (RULE_11) restart rising edge sets the instant the chain starts processing
// (RULE_12) first frame strobe falls a fixed mode-dependent count after restart rise
// (RULE_13) each conversion period is marked by a frame strobe falling edge
// (RULE_14) input change reaches output after 28 output-rate periods in every mode
// (RULE_15) fine group delay equals computation delay plus filter delay
// (RULE_16) each frame strobe pulse lasts exactly 32 serial clock periods
// (RULE_17) restart falling edge resets the filter state
// (RULE_18) settled flag clears on restart and stays clear until settling completes
`ifndef DECIM_CFG_SVH
`define DECIM_CFG_SVH

// ****************************************
// clock division and decimation
// ****************************************
`define DIV_NORMAL     3'h2
`define DIV_LOW        3'h4
`define S1_FACTOR      6'h04
`define S2_N128        6'h10
`define S2_N256        6'h20
`define S2_L128        6'h08
`define S2_L256        6'h10
`define S3_FACTOR      6'h02
`define ODR_128        16'h0080
`define ODR_256        16'h0100
`define FRAME_BITS     6'h20
`define GD_ODR_PERIODS 5'h1c

// ****************************************
// delays in master clock periods
// ****************************************
`define OFFS_N128  16'h008d
`define OFFS_N256  16'h00fc
`define OFFS_L128  16'h00a7
`define OFFS_L256  16'h0115
`define SETL_N128  16'h368e
`define SETL_N256  16'h6cfd
`define SETL_L128  16'h37a8
`define SETL_L256  16'h6d16
`define COMP_N128  16'h0071
`define COMP_N256  16'h01bb
`define COMP_L128  16'h00a2
`define COMP_L256  16'h00e0
`define FILT_N128  16'h1b30
`define FILT_N256  16'h3528
`define FILT_L128  16'h1b60
`define FILT_L256  16'h3660

`endif

/* File: include/decim_pkg.sv */
// types shared by the decimation chain
package decim_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_OFFSET, ST_RUN} sync_state_type;
  typedef logic [15:0] mclk_count_type;
endpackage : decim_pkg

/* File: verification/frame_receiver.sv */
// host side model that collects framed result words
`timescale 1ns/1ps
module frame_receiver (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        modulator_sample_clock,
  input  wire logic        frame_strobe_out,
  input  wire logic        serial_data_out,
  output logic [31:0]      word_ff,
  output logic [15:0]      word_cnt_ff,
  output logic [15:0]      width_err_ff
);
  logic [31:0] shift_ff;
  logic [4:0]  bit_ff;
  logic        fso_d_ff;
  wire  [31:0] nxt_shift = {shift_ff[30:0], serial_data_out};
  wire         take_bit  = !frame_strobe_out && modulator_sample_clock;

  // ****************************************
  // serial capture
  // ****************************************
  // one word per strobe period
  // counting bits, not strobe edges, keeps back-to-back frames working
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shift_ff     <= 32'h0;
      bit_ff       <= 5'h0;
      fso_d_ff     <= 1'b1;
      word_ff      <= 32'h0;
      word_cnt_ff  <= 16'h0;
      width_err_ff <= 16'h0;
    end else begin
      fso_d_ff <= frame_strobe_out;
      if (take_bit) begin
        shift_ff <= nxt_shift;
        bit_ff   <= bit_ff + 5'h1;
        if (bit_ff == 5'h1f) begin
          word_ff     <= nxt_shift;
          word_cnt_ff <= word_cnt_ff + 16'h1;
        end
      end else if (frame_strobe_out) begin
        bit_ff <= 5'h0;
        if (!fso_d_ff && bit_ff != 5'h0) begin
          width_err_ff <= width_err_ff + 16'h1;
        end
      end
    end
  end
endmodule : frame_receiver

/* File: verification/tb_top.sv */
// testbench for the decimation chain and restart timing
`timescale 1ns/1ps
`include "decim_cfg.svh"
module tb_top;
  localparam logic [15:0] SET_N128 = 16'h0190;
  localparam logic [15:0] SET_N256 = 16'h0384;
  localparam logic [15:0] SET_L128 = 16'h01c2;
  localparam logic [15:0] SET_L256 = 16'h03b6;

  logic        clock             = 1'b0;
  logic        sys_rst           = 1'b1;
  logic        restart_pin       = 1'b0;
  logic        decimation_select = 1'b0;
  logic        low_power         = 1'b0;
  logic [15:0] mod_word          = 16'h0003;
  logic        modulator_sample_clock;
  logic        serial_clock_out;
  logic        frame_strobe_out;
  logic        serial_data_out;
  logic        settled_flag;
  logic [15:0] fine_group_delay;
  logic [31:0] word;
  logic [15:0] word_cnt;
  logic [15:0] width_err;
  int          err_total = 0;
  int          compares  = 0;
  time         t_rise;

  always #2.5 clock = ~clock;

  decim_top #(.SETTLE_N128(SET_N128), .SETTLE_N256(SET_N256),
              .SETTLE_L128(SET_L128), .SETTLE_L256(SET_L256)) decim_top_i (
    .clock(clock), .sys_rst(sys_rst), .restart_pin(restart_pin),
    .decimation_select(decimation_select), .low_power(low_power), .mod_word(mod_word),
    .modulator_sample_clock(modulator_sample_clock), .serial_clock_out(serial_clock_out),
    .frame_strobe_out(frame_strobe_out), .serial_data_out(serial_data_out),
    .settled_flag(settled_flag), .fine_group_delay(fine_group_delay));

  frame_receiver frame_receiver_i (
    .clock(clock), .sys_rst(sys_rst), .modulator_sample_clock(modulator_sample_clock),
    .frame_strobe_out(frame_strobe_out), .serial_data_out(serial_data_out),
    .word_ff(word), .word_cnt_ff(word_cnt), .width_err_ff(width_err));

  // ****************************************
  // helpers
  // ****************************************
  task automatic test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check

  // edge placement of a synchronised pin is only known to one cycle
  task automatic check_rng(input int got, input int exp);
    compares++;
    if (got < exp + 2 || got > exp + 4) begin
      err_total++;
      $display("Error t=%0t exp=%h got=%h", $time, exp + 3, got);
    end
  endtask : check_rng

  task automatic step;
    @(posedge clock);
    #1;
  endtask : step

  function automatic logic pick(input int sel);
    case (sel)
      0:       pick = frame_strobe_out;
      1:       pick = settled_flag;
      default: pick = modulator_sample_clock;
    endcase
  endfunction : pick

  task automatic wait_for(input int sel, input logic lvl, input int limit, output int n);
    n = 0;
    while (pick(sel) !== lvl) begin
      step();
      n++;
      if (n > limit) begin
        err_total++;
        $display("Error t=%0t exp=%h got=%h", $time, lvl, pick(sel));
        test_done();
      end
    end
  endtask : wait_for

  function automatic int since_rise;
    since_rise = int'(($time - t_rise) / 5);
  endfunction : since_rise

  // ****************************************
  // scenarios
  // ****************************************
  task automatic reset_state;
    check({frame_strobe_out, serial_clock_out, fine_group_delay}, 32'h20000);
    check(settled_flag, 1'b0);
  endtask : reset_state

  task automatic mode_timing(input logic lp, input logic d);
    int          n;
    int          n2;
    int          offs;
    int          setl;
    int          words;
    logic [15:0] gd;
    logic [15:0] we0;
    logic [15:0] w0;
    offs  = lp ? (d ? `OFFS_L128 : `OFFS_L256) : (d ? `OFFS_N128 : `OFFS_N256);
    setl  = lp ? (d ? SET_L128 : SET_L256) : (d ? SET_N128 : SET_N256);
    gd    = lp ? (d ? `COMP_L128 + `FILT_L128 : `COMP_L256 + `FILT_L256)
               : (d ? `COMP_N128 + `FILT_N128 : `COMP_N256 + `FILT_N256);
    words = (d ? 128 : 256) / (lp ? 2 : 1);
    low_power         = lp;
    decimation_select = d;
    repeat (4) step();
    // pin is synchronised, so driving after the rising edge costs one cycle at most
    restart_pin = 1'b1;
    t_rise      = $time;
    we0         = width_err;
    wait_for(0, 1'b0, 400, n);
    check_rng(since_rise(), offs);
    check(settled_flag, 1'b0);
    check(fine_group_delay, gd);
    wait_for(2, 1'b1, 8, n);
    step();
    wait_for(2, 1'b1, 8, n);
    check(n + 1, lp ? 4 : 2);
    if (!(lp && d)) begin
      wait_for(0, 1'b1, 300, n);
      wait_for(0, 1'b0, 300, n2);
      wait_for(0, 1'b1, 300, n);
      wait_for(0, 1'b0, 300, n2);
      check(n + n2, d ? 128 : 256);
    end
    wait_for(1, 1'b1, 1000, n);
    check_rng(since_rise(), setl);
    w0 = word_cnt;
    // second word after settling is the first one surely fed by a full window
    for (int i = 0; i < 700 && word_cnt < w0 + 16'h2; i++) begin
      step();
    end
    check(word_cnt - w0, 32'h2);
    check(word[31:8], 3 * words);
    check(word[7:0], {1'b1, lp, d, 5'h0});
    check(width_err, we0);
  endtask : mode_timing

  task automatic restart_abort;
    int          n;
    logic [15:0] w;
    restart_pin = 1'b0;
    wait_for(1, 1'b0, 6, n);
    step();
    check(frame_strobe_out, 1'b1);
    w = word_cnt;
    repeat (300) step();
    check(settled_flag, 1'b0);
    check(word_cnt, w);
  endtask : restart_abort

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clock);
    #1;
    reset_state();
    sys_rst = 1'b0;
    step();
    for (int m = 0; m < 4; m++) begin
      mode_timing(m[1], m[0]);
      restart_abort();
    end
    test_done();
  end
endmodule : tb_top
